// ==== design/sfp_framer.sv ====
// Synchronous modem character framer with APB registers and block channel
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module sfp_framer
    import sfp_pkg::*;
#(
    parameter bit P_ODD_PARITY = 1'b0
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Block transfer channel
    input wire logic i_btc_wr_ack,
    input wire logic i_btc_rd_ack,
    input wire logic [15:0] i_btc_rd_data,
    input wire logic i_btc_wcc,
    output sfp_btc_type o_btc,
    // Modem
    input wire logic i_rxd,
    input wire logic i_rx_timing,
    input wire logic i_tx_timing,
    input wire logic i_cts,
    output logic o_txd,
    output logic o_rts,
    // Interrupt lines
    output logic o_in_irq,
    output logic o_out_irq,
    output logic o_sync_irq
);
    // Shifters and word packing are built for two 8-bit characters per 16-bit word
    if (CHAR_W != 8 || WORD_W != 2 * CHAR_W)
    begin
        $error("sfp_framer supports only 8-bit characters in 16-bit words");
    end

    // -------------------------------------------------------------------------
    // Synchronisers and edge detection
    // -------------------------------------------------------------------------
    logic rxc_s1_q, rxc_s2_q, rxc_s3_q, rxd_s1_q, rxd_s2_q;
    logic txc_s1_q, txc_s2_q, txc_s3_q, cts_s1_q, cts_s2_q;
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            {rxc_s1_q, rxc_s2_q, rxc_s3_q, rxd_s1_q, rxd_s2_q} <= 5'h1F;
            // Transmit timing resets low so that leaving reset can never look like a fall
            {txc_s1_q, txc_s2_q, txc_s3_q, cts_s1_q, cts_s2_q} <= 5'h00;
        end
        else
        begin
            rxc_s1_q <= i_rx_timing;
            rxc_s2_q <= rxc_s1_q;
            rxc_s3_q <= rxc_s2_q;
            rxd_s1_q <= i_rxd;
            rxd_s2_q <= rxd_s1_q;
            txc_s1_q <= i_tx_timing;
            txc_s2_q <= txc_s1_q;
            txc_s3_q <= txc_s2_q;
            cts_s1_q <= i_cts;
            cts_s2_q <= cts_s1_q;
        end
    end
    // Receive samples on the rising edge, transmit changes on the falling one
    wire rx_edge = rxc_s2_q & ~rxc_s3_q;
    wire tx_fall = ~txc_s2_q & txc_s3_q;

    // -------------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------------
    logic pready_q, pslverr_q, snap_word_q, snap_pend_q;
    logic [31:0] prdata_q;
    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable & pready_q;
    wire wr_acc = access & i_pwrite;
    wire rd_acc = access & ~i_pwrite;
    wire mapped = i_paddr == OFF_CTRL || i_paddr == OFF_STAT || i_paddr == OFF_DIN
        || i_paddr == OFF_DOUT || i_paddr == OFF_SYNC;
    wire ctrl_wr = wr_acc && i_paddr == OFF_CTRL;
    wire hunt_cmd = ctrl_wr && i_pwdata[CB_HUNT];
    wire stop_cmd = ctrl_wr && !i_pwdata[CB_HUNT];
    wire dout_wr = wr_acc && i_paddr == OFF_DOUT;
    wire din_rd = rd_acc && i_paddr == OFF_DIN;
    wire stat_rd = rd_acc && i_paddr == OFF_STAT;

    // -------------------------------------------------------------------------
    // Configuration
    // -------------------------------------------------------------------------
    sfp_mode_type mode_q;
    logic [7:0] sync1_q, sync2_q;
    logic rts_q, btc_on_q, btc_in_q, out_arm_q;
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            mode_q <= '0;
        else if (ctrl_wr && i_pwdata[CB_PROT])
            mode_q <= '{char_mode: i_pwdata[CB_CHAR], par_en: i_pwdata[CB_PAR]};
    end
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            sync1_q <= SYNC1_RST;
            sync2_q <= SYNC2_RST;
        end
        else if (wr_acc && i_paddr == OFF_SYNC)
        begin
            sync1_q <= i_pwdata[7:0];
            sync2_q <= i_pwdata[15:8];
        end
    end
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            rts_q <= 1'b0;
            btc_on_q <= 1'b0;
            btc_in_q <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            if (i_pwdata[CB_RTS_ON])
                rts_q <= 1'b1;
            else if (i_pwdata[CB_RTS_OFF])
                rts_q <= 1'b0;
            btc_on_q <= i_pwdata[CB_BTC];
            if (i_pwdata[CB_BTC])
                btc_in_q <= i_pwdata[CB_SIM];
        end
    end
    wire btc_rx = btc_on_q & btc_in_q;
    wire btc_tx = btc_on_q & ~btc_in_q;
    wire [7:0] par_init = P_ODD_PARITY ? PAR_ODD_INIT : PAR_EVEN_INIT;

    // -------------------------------------------------------------------------
    // Receive shifter and framing
    // -------------------------------------------------------------------------
    sfp_rx_state_type rx_state_q;
    logic [7:0] rx_sr_q, rx_par_q, hold_q, par_char_q;
    logic [2:0] rx_cnt_q;
    logic hold_v_q, half_q, word_v_q, par_pend_q;
    logic [15:0] word_q;
    wire [7:0] rx_next = {rxd_s2_q, rx_sr_q[7:1]};
    wire char_done = rx_edge && rx_cnt_q == 3'h7;
    wire sync1_hit = rx_next == sync1_q;
    wire sync2_hit = rx_next == sync2_q;
    wire data_char = char_done && rx_state_q == RX_DATA;
    wire last_char = char_done && rx_state_q == RX_LAST;
    wire par_ok = rx_par_q == 8'h00;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            rx_sr_q <= 8'h00;
        else if (rx_edge)
            rx_sr_q <= rx_next;
    end
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || hunt_cmd || (rx_state_q == RX_HUNT1 && rx_edge && sync1_hit))
            rx_cnt_q <= 3'h0;
        else if (rx_edge)
            rx_cnt_q <= rx_cnt_q + 3'h1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            rx_state_q <= RX_OFF;
        else if (hunt_cmd)
            rx_state_q <= RX_HUNT1;
        else
        begin
            unique case (rx_state_q)
                RX_OFF:
                    rx_state_q <= RX_OFF;
                RX_HUNT1:
                    if (stop_cmd)
                        rx_state_q <= RX_OFF;
                    else if (rx_edge && sync1_hit)
                        rx_state_q <= RX_HUNT2;
                RX_HUNT2:
                    if (stop_cmd)
                        rx_state_q <= RX_OFF;
                    else if (char_done)
                        rx_state_q <= sync2_hit ? RX_DATA : RX_HUNT1;
                RX_DATA:
                    if (stop_cmd || (btc_rx && i_btc_wcc))
                        rx_state_q <= RX_LAST;
                RX_LAST:
                    if (char_done)
                        rx_state_q <= RX_HOLD;
                RX_HOLD:
                    rx_state_q <= RX_HOLD;
                default:
                    rx_state_q <= RX_OFF;
            endcase
        end
    end

    logic sync_irq_q;
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            sync_irq_q <= 1'b0;
        else
            sync_irq_q <= !hunt_cmd && !stop_cmd && rx_state_q == RX_HUNT2
                && char_done && sync2_hit;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            rx_par_q <= PAR_EVEN_INIT;
        else if (hunt_cmd)
            rx_par_q <= par_init;
        else if (data_char || last_char)
            rx_par_q <= rx_par_q ^ rx_next;
    end

    // Holding buffer, then word assembly one cycle later
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            hold_q <= 8'h00;
            hold_v_q <= 1'b0;
        end
        else
        begin
            hold_v_q <= data_char;
            if (data_char)
                hold_q <= rx_next;
        end
    end
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || hunt_cmd)
        begin
            half_q <= 1'b0;
            word_v_q <= 1'b0;
            word_q <= 16'h0000;
        end
        else
        begin
            // Consumed by the host or the channel; a new word on the same edge wins
            if ((din_rd && snap_word_q) || (o_btc.wr_req && i_btc_wr_ack))
                word_v_q <= 1'b0;
            if (hold_v_q)
            begin
                if (mode_q.char_mode)
                begin
                    word_q <= {8'h00, hold_q};
                    word_v_q <= 1'b1;
                end
                else if (!half_q)
                begin
                    word_q[7:0] <= hold_q;
                    half_q <= 1'b1;
                end
                else
                begin
                    word_q[15:8] <= hold_q;
                    half_q <= 1'b0;
                    word_v_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            par_char_q <= 8'h00;
        else if (last_char)
            par_char_q <= rx_next;
    end
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            par_pend_q <= 1'b0;
        else if (last_char && !btc_rx)
            par_pend_q <= 1'b1;
        else if (hunt_cmd || stat_rd || (din_rd && snap_pend_q))
            par_pend_q <= 1'b0;
    end

    logic in_irq_q;
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            in_irq_q <= 1'b0;
        else
            in_irq_q <= (word_v_q && !btc_rx) || par_pend_q;
    end

    // -------------------------------------------------------------------------
    // Transmit disassembly and serialiser
    // -------------------------------------------------------------------------
    logic [15:0] dis_q;
    logic [1:0] dis_n_q;
    logic [7:0] tx_sr_q, tx_par_q;
    logic [3:0] tx_left_q;
    logic wcc_seen_q, par_sent_q, txd_q, out_irq_q;
    wire ser_ready = tx_left_q == 4'h0;
    wire take_char = ser_ready && dis_n_q != 2'h0;
    wire send_par = ser_ready && dis_n_q == 2'h0 && btc_tx && mode_q.par_en
        && wcc_seen_q && !par_sent_q;
    wire [7:0] next_char = (dis_n_q == 2'h2 || mode_q.char_mode) ? dis_q[7:0] : dis_q[15:8];
    wire btc_load = o_btc.rd_req && i_btc_rd_ack;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            dis_q <= 16'h0000;
            dis_n_q <= 2'h0;
        end
        else if (dout_wr || btc_load)
        begin
            dis_q <= dout_wr ? i_pwdata[15:0] : i_btc_rd_data;
            dis_n_q <= mode_q.char_mode ? 2'h1 : 2'h2;
        end
        else if (take_char)
            dis_n_q <= dis_n_q - 2'h1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            tx_sr_q <= 8'h00;
            tx_left_q <= 4'h0;
            txd_q <= 1'b1;
        end
        else if (take_char || send_par)
        begin
            tx_sr_q <= take_char ? next_char : tx_par_q;
            tx_left_q <= BITS_PER_CHAR;
        end
        else if (tx_fall)
        begin
            // Mark idle once a character has gone and nothing follows
            txd_q <= ser_ready ? 1'b1 : tx_sr_q[0];
            tx_sr_q <= {1'b0, tx_sr_q[7:1]};
            if (!ser_ready)
                tx_left_q <= tx_left_q - 4'h1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            tx_par_q <= PAR_EVEN_INIT;
        else if (hunt_cmd)
            tx_par_q <= par_init;
        else if (take_char)
            tx_par_q <= tx_par_q ^ next_char;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || (ctrl_wr && i_pwdata[CB_BTC]))
        begin
            wcc_seen_q <= 1'b0;
            par_sent_q <= 1'b0;
        end
        else
        begin
            if (btc_tx && i_btc_wcc)
                wcc_seen_q <= 1'b1;
            if (send_par)
                par_sent_q <= 1'b1;
        end
    end

    // Output interrupt is armed by the first programmed word, so it stays quiet after reset
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || btc_tx)
            out_arm_q <= 1'b0;
        else if (dout_wr)
            out_arm_q <= 1'b1;
    end
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            out_irq_q <= 1'b0;
        else
            out_irq_q <= out_arm_q && !btc_tx && dis_n_q == 2'h0 && !dout_wr;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            o_btc <= '0;
        else
        begin
            o_btc.wr_req <= word_v_q && btc_rx && !(o_btc.wr_req && i_btc_wr_ack);
            o_btc.wr_data <= word_q;
            o_btc.rd_req <= btc_tx && dis_n_q == 2'h0 && !wcc_seen_q && !i_btc_wcc
                && !btc_load;
        end
    end

    // -------------------------------------------------------------------------
    // APB answer: one wait-free access, data latched in the setup cycle
    // -------------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (i_paddr)
            OFF_CTRL:
                rd_mux = {18'h0_0000, mode_q.char_mode, mode_q.par_en, 6'h00, rts_q, 3'h0,
                    btc_in_q, btc_on_q};
            OFF_STAT:
            begin
                rd_mux[SB_CTS] = cts_s2_q;
                rd_mux[SB_PAR_OK] = par_ok;
                rd_mux[SB_WORD] = word_v_q;
                rd_mux[SB_PAR_PEND] = par_pend_q;
                rd_mux[SB_STATE +: 3] = rx_state_q;
            end
            OFF_DIN:
                rd_mux[15:0] = rx_state_q == RX_HOLD ? {8'h00, par_char_q} : word_q;
            OFF_SYNC:
                rd_mux[15:0] = {sync2_q, sync1_q};
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            snap_word_q <= 1'b0;
            snap_pend_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            snap_word_q <= word_v_q;
            snap_pend_q <= par_pend_q;
            if (setup && !i_pwrite)
                prdata_q <= rd_mux;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_txd = txd_q;
    assign o_rts = rts_q;
    assign o_in_irq = in_irq_q;
    assign o_out_irq = out_irq_q;
    assign o_sync_irq = sync_irq_q;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_hunt_cmd_enters: assert property (hunt_cmd |=> rx_state_q == RX_HUNT1)
        else $error("hunt command did not enter hunt");
    a_hunt_first_match: assert property (rx_state_q == RX_HUNT1 && rx_edge && sync1_hit
        && !ctrl_wr |=> rx_state_q == RX_HUNT2)
        else $error("first sync match missed");
    a_hunt_second_char: assert property (rx_state_q == RX_HUNT2 && char_done && !ctrl_wr
        |=> (rx_state_q == RX_DATA) == $past(sync2_hit))
        else $error("second sync decision wrong");
    a_sync_irq_pulse: assert property (rx_state_q == RX_DATA
        && $past(rx_state_q) == RX_HUNT2 |-> sync_irq_q ##1 !sync_irq_q)
        else $error("sync interrupt not a single pulse");
    a_parity_toggle: assert property ((data_char || last_char) && !hunt_cmd
        |=> rx_par_q == ($past(rx_par_q) ^ $past(rx_next)))
        else $error("receive parity not XOR of character");
    a_parity_init: assert property (hunt_cmd |=> rx_par_q == par_init && tx_par_q == par_init)
        else $error("parity not initialised on hunt");
    a_last_char_stop: assert property (last_char && !hunt_cmd |=> rx_state_q == RX_HOLD)
        else $error("receive did not stop after parity char");
    a_word_irq: assert property (word_v_q && !btc_rx |=> in_irq_q)
        else $error("input interrupt missing for word");
    a_status_skip: assert property (setup && !i_pwrite && i_paddr == OFF_STAT
        |=> prdata_q[SB_PAR_OK] == ($past(rx_par_q) == 8'h00))
        else $error("parity status bit wrong");
    a_tx_shift_out: assert property (tx_fall && !ser_ready && !take_char && !send_par
        |=> txd_q == $past(tx_sr_q[0]) && tx_left_q == $past(tx_left_q) - 4'h1)
        else $error("serialiser did not shift");

    c_sync_found: cover property (rx_state_q == RX_HUNT2 ##[1:200] rx_state_q == RX_DATA);
    c_parity_held: cover property (last_char ##1 rx_state_q == RX_HOLD);
    c_tx_parity: cover property (send_par);
    c_word_read: cover property (word_v_q && din_rd);
endmodule

// ==== design/sfp_pkg.sv ====
// Constants, register map and types of the synchronous modem framer
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package sfp_pkg;
    localparam int CHAR_W = 8;
    localparam int WORD_W = 16;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DIN = 8'h08;
    localparam logic [7:0] OFF_DOUT = 8'h0C;
    localparam logic [7:0] OFF_SYNC = 8'h10;
    localparam int CB_BTC = 0;
    localparam int CB_RTS_ON = 4;
    localparam int CB_RTS_OFF = 5;
    localparam int CB_HUNT = 6;
    localparam int CB_PROT = 10;
    localparam int CB_PAR = 11;
    localparam int CB_CHAR = 12;
    localparam int CB_SIM = 14;
    localparam int SB_CTS = 1;
    localparam int SB_PAR_OK = 5;
    localparam int SB_WORD = 8;
    localparam int SB_PAR_PEND = 9;
    localparam int SB_STATE = 12;
    localparam logic [7:0] SYNC1_RST = 8'h55;
    localparam logic [7:0] SYNC2_RST = 8'h32;
    localparam logic [7:0] PAR_EVEN_INIT = 8'h00;
    localparam logic [7:0] PAR_ODD_INIT = 8'hFF;
    localparam logic [3:0] BITS_PER_CHAR = 4'h8;

    typedef enum logic [2:0]
    {
        RX_OFF = 3'b000,
        RX_HUNT1 = 3'b001,
        RX_HUNT2 = 3'b010,
        RX_DATA = 3'b011,
        RX_LAST = 3'b100,
        RX_HOLD = 3'b101
    } sfp_rx_state_type;

    typedef struct packed
    {
        logic char_mode;
        logic par_en;
    } sfp_mode_type;

    typedef struct packed
    {
        logic wr_req;
        logic rd_req;
        logic [15:0] wr_data;
    } sfp_btc_type;
endpackage

// ==== testbench/sfp_framer_tb.sv ====
// Self-checking bench for the synchronous modem framer
`timescale 1ns/1ns
module sfp_framer_tb;
    import sfp_pkg::*;
    // ----------------------------------------
    // Signals and checks
    // ----------------------------------------
    logic i_clock, i_sys_rst, i_psel, i_penable, i_pwrite, i_cts;
    logic [7:0] i_paddr, ch, d0, d1;
    logic [31:0] i_pwdata, o_prdata;
    logic o_pready, o_pslverr, o_txd, o_rts, o_in_irq, o_out_irq, o_sync_irq;
    logic rxd, rx_t, tx_t, ch_vld, wr_ack, rd_ack, wcc;
    logic [15:0] rd_data, w0, w1;
    sfp_btc_type o_btc;
    logic [32:0] exp_rd[$];
    logic [32:0] msk_rd[$];
    logic [7:0] exp_tx[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int n_sync = 0;

    sfp_framer dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_btc_wr_ack(wr_ack), .i_btc_rd_ack(rd_ack), .i_btc_rd_data(rd_data), .i_btc_wcc(wcc),
        .o_btc(o_btc), .i_rxd(rxd), .i_rx_timing(rx_t), .i_tx_timing(tx_t), .i_cts(i_cts),
        .o_txd(o_txd), .o_rts(o_rts), .o_in_irq(o_in_irq), .o_out_irq(o_out_irq),
        .o_sync_irq(o_sync_irq));
    sfp_modem_model modem (.i_clock(i_clock), .i_txd(o_txd), .o_rxd(rxd), .o_rx_timing(rx_t),
        .o_tx_timing(tx_t), .o_char(ch), .o_char_vld(ch_vld));

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge i_clock)
        if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite)
            check("prdata", {o_pslverr, o_prdata} & msk_rd.pop_front(), exp_rd.pop_front());
    always @(posedge ch_vld)
        check("tx char", 33'(ch), 33'(exp_tx.pop_front()));
    always @(posedge i_clock)
        if (o_sync_irq === 1'b1)
            n_sync++;
    // ----------------------------------------
    // Bus tasks and sequence
    // ----------------------------------------
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do
            @(posedge i_clock);
        while (o_pready !== 1'b1 && ++k < 20);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (k >= 20)
        begin
            check("pready", 33'(o_pready), 33'h0_0000_0001);
            close_out();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] e);
        msk_rd.push_back(m);
        exp_rd.push_back(e);
        apb(a, 1'b0, 32'h0000_0000);
    endtask

    // Waits for input interrupt (0), channel fetch (1) or channel store (2) request
    task automatic wait_in_irq(input int sel = 0);
        int k;
        k = 0;
        do
            @(posedge i_clock);
        while ((sel == 0 ? o_in_irq : sel == 1 ? o_btc.rd_req : o_btc.wr_req) !== 1'b1
            && ++k < 300);
        if (k >= 300)
        begin
            n_mismatch++;
            close_out();
        end
    endtask

    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    initial
    begin
        {i_sys_rst, i_psel, i_penable, i_pwrite, i_cts} = 5'b10000;
        i_paddr = 8'h00;
        i_pwdata = 32'h0000_0000;
        {wr_ack, rd_ack, wcc} = 3'h0;
        rd_data = 16'h0000;
        void'($urandom(39962));
        repeat (16) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        i_cts <= 1'b1;
        rd(OFF_CTRL, 33'h1_FFFF_FFFF, 33'h0_0000_0000);
        rd(OFF_SYNC, 33'h0_0000_FFFF, {17'h0_0000, SYNC2_RST, SYNC1_RST});
        rd(8'h14, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
        apb(OFF_CTRL, 1'b1, 32'h0000_1810);
        rd(OFF_CTRL, 33'h0_0000_3020, 33'h0_0000_0020);
        apb(OFF_CTRL, 1'b1, 32'h0000_1C00);
        rd(OFF_CTRL, 33'h0_0000_3020, 33'h0_0000_3020);
        apb(OFF_CTRL, 1'b1, 32'h0000_0400);
        rd(OFF_STAT, 33'h0_0000_7302, 33'h0_0000_0002);
        apb(OFF_SYNC, 1'b1, 32'h0000_3C96);
        apb(OFF_CTRL, 1'b1, 32'h0000_0040);
        modem.send_byte(8'h00);
        modem.send_byte(8'h96);
        // A zero filler cannot alias the first sync pattern at any bit offset
        modem.send_byte(8'h00);
        repeat (10) @(posedge i_clock);
        rd(OFF_STAT, 33'h0_0000_7000, 33'h0_0000_1000);
        modem.send_byte(8'h96);
        modem.send_byte(8'h3C);
        d0 = 8'($urandom);
        d1 = d0 ^ 8'($urandom_range(255, 1));
        modem.send_byte(d0);
        modem.send_byte(d1);
        wait_in_irq();
        check("sync pulses", 33'(n_sync), 33'h0_0000_0001);
        rd(OFF_STAT, 33'h0_0000_7122, 33'h0_0000_3102);
        rd(OFF_DIN, 33'h0_0000_FFFF, {17'h0_0000, d1, d0});
        apb(OFF_CTRL, 1'b1, 32'h0000_0000);
        modem.send_byte(d0 ^ d1);
        wait_in_irq();
        rd(OFF_DIN, 33'h0_0000_00FF, 33'(d0 ^ d1));
        rd(OFF_STAT, 33'h0_0000_7020, 33'h0_0000_5020);
        check("in irq", 33'(o_in_irq), 33'h0_0000_0000);
        exp_tx.push_back(8'h12);
        exp_tx.push_back(8'hAB);
        apb(OFF_DOUT, 1'b1, 32'h0000_AB12);
        modem.run_tx(20);
        check("out irq", 33'(o_out_irq), 33'h0_0000_0001);
        check("tx left", 33'(exp_tx.size()), 33'h0_0000_0000);
        // Block output: two fetched words, then the parity character after word count
        w0 = 16'($urandom) & 16'hFFFE;
        w1 = 16'($urandom);
        exp_tx.push_back(w0[7:0]);
        exp_tx.push_back(w0[15:8]);
        exp_tx.push_back(w1[7:0]);
        exp_tx.push_back(w1[15:8]);
        exp_tx.push_back(w0[7:0] ^ w0[15:8] ^ w1[7:0] ^ w1[15:8]);
        apb(OFF_CTRL, 1'b1, 32'h0000_0C41);
        fork
            modem.run_tx(46);
            for (int i = 0; i < 2; i++)
            begin
                wait_in_irq(1);
                rd_ack <= 1'b1;
                rd_data <= i ? w1 : w0;
                wcc <= i == 1;
                @(posedge i_clock);
                rd_ack <= 1'b0;
            end
        join
        check("tx left", 33'(exp_tx.size()), 33'h0_0000_0000);
        check("rd req", 33'(o_btc.rd_req), 33'h0_0000_0000);
        check("out irq", 33'(o_out_irq), 33'h0_0000_0000);
        // Block input: one word over the channel, then the parity character ends reception
        wcc <= 1'b0;
        apb(OFF_CTRL, 1'b1, 32'h0000_4041);
        modem.send_byte(8'h00);
        modem.send_byte(8'h96);
        modem.send_byte(8'h3C);
        modem.send_byte(d0);
        modem.send_byte(d1);
        wait_in_irq(2);
        check("wr data", 33'(o_btc.wr_data), {17'h0_0000, d1, d0});
        wr_ack <= 1'b1;
        wcc <= 1'b1;
        @(posedge i_clock);
        wr_ack <= 1'b0;
        modem.send_byte(d0 ^ d1);
        rd(OFF_STAT, 33'h0_0000_7320, 33'h0_0000_5020);
        close_out();
    end
endmodule

// ==== testbench/sfp_modem_model.sv ====
// Behavioural synchronous modem: receive bit source and transmit bit sink
`timescale 1ns/1ns
module sfp_modem_model
(
    // Clock
    input wire logic i_clock,
    // Modem lines
    input wire logic i_txd,
    output logic o_rxd = 1'b1,
    output logic o_rx_timing = 1'b0,
    output logic o_tx_timing = 1'b0,
    // Captured transmit characters
    output logic [7:0] o_char = 8'h00,
    output logic o_char_vld = 1'b0
);
    logic [7:0] sh = 8'h00;
    int nbit = -1;

    // Timing stands still between characters; data settles half a bit before the rise
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge i_clock);
            o_rx_timing <= 1'b0;
            o_rxd <= b[i];
            repeat (4) @(posedge i_clock);
            o_rx_timing <= 1'b1;
            repeat (3) @(posedge i_clock);
        end
        @(posedge i_clock);
        o_rxd <= ~b[7];
    endtask

    // Bits taken at the end of the high phase, long after the line has moved
    task automatic run_tx(input int n);
        // Each run frames afresh on the first zero, so a run's first character needs bit 0 clear
        nbit = -1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge i_clock);
            o_tx_timing <= 1'b0;
            o_char_vld <= 1'b0;
            repeat (4) @(posedge i_clock);
            o_tx_timing <= 1'b1;
            repeat (3) @(posedge i_clock);
            if (nbit < 0 && i_txd === 1'b0)
                nbit = 0;
            if (nbit >= 0)
            begin
                sh = {i_txd, sh[7:1]};
                nbit++;
                if (nbit == 8)
                begin
                    o_char <= sh;
                    o_char_vld <= 1'b1;
                    nbit = 0;
                end
            end
        end
    endtask
endmodule
